// File: hw/emcfg_top.sv
// The Avalon-MM interface to the registers and the register offsets were decided locally.
module emcfg_top
  import emcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu external move request
  input wire logic xmove_start,
  input wire logic xmove_is_write,
  input wire logic xmove_wide,
  input wire logic [15:0] xmove_wide_addr,
  input wire logic [7:0] xmove_low_addr,
  input wire logic [7:0] xmove_wdata,
  output logic xmove_done,
  output logic [7:0] xmove_rdata,
  output logic xmove_onchip,
  output logic [15:0] xmove_eff_addr,
  // ports 7..4 as {p7,p6,p5,p4}
  input wire logic [31:0] port_latch,
  input wire logic [31:0] port_pin_in,
  output logic [31:0] port_pin_out,
  output logic [31:0] port_pin_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and bus slave
  logic [7:0] high_page_bits_q;
  logic [7:0] ext_mem_config_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  logic last_offchip_q;
  emcfg_state_t state_q, state_d;
  logic bus_req;
  logic bus_take;
  logic [31:0] rd_mux;

  logic pin_route_enable;
  logic mux_select;
  emcfg_map_t map_mode;
  logic [1:0] latch_pulse_width;

  assign pin_route_enable = ext_mem_config_q[EMCFG_ROUTE_BIT];
  assign mux_select = ext_mem_config_q[EMCFG_MUX_BIT];
  assign map_mode = emcfg_map_t'(ext_mem_config_q[EMCFG_MODE_LSB +: 2]);
  assign latch_pulse_width = ext_mem_config_q[EMCFG_ALE_LSB +: 2];

  assign bus_req = avs_read | avs_write;
  // a request is answered one clock after it appears; taken while waitrequest low
  assign bus_take = bus_req & ~waitrequest_q;

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      EMCFG_PAGE_OFS: rd_mux = {24'h0, high_page_bits_q};
      EMCFG_CFG_OFS: rd_mux = {24'h0, ext_mem_config_q & EMCFG_CFG_WMASK};
      EMCFG_STAT_OFS: rd_mux = {30'h0, last_offchip_q, state_q != EMCFG_ST_IDLE};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0;
    end else if (bus_take) begin
      waitrequest_q <= 1'b1;
    end else if (bus_req) begin
      waitrequest_q <= 1'b0;
      readdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_page_bits_q <= EMCFG_PAGE_RST;
    end else if (bus_take && avs_write && avs_byteenable[0]
                 && avs_address == EMCFG_PAGE_OFS) begin
      high_page_bits_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_mem_config_q <= EMCFG_CFG_RST;
    end else if (bus_take && avs_write && avs_byteenable[0]
                 && avs_address == EMCFG_CFG_OFS) begin
      ext_mem_config_q <= avs_writedata[7:0] & EMCFG_CFG_WMASK;
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitrequest_q;

  ////////////////////////////////////////////////////////////////////////////
  // address formation and map decode
  logic [15:0] eff_addr;
  logic offchip;
  logic op_write_q, op_wide_q, op_offchip_q, op_mux_q;
  logic [15:0] op_addr_q;
  logic [7:0] op_wdata_q;

  // 8-bit moves take the high byte from the page register
  assign eff_addr = xmove_wide ? xmove_wide_addr : {high_page_bits_q, xmove_low_addr};

  always_comb begin
    case (map_mode)
      EMCFG_MAP_ONCHIP: offchip = 1'b0;
      EMCFG_MAP_SPLIT_NOBANK: offchip = eff_addr >= EMCFG_ONCHIP_LIMIT;
      EMCFG_MAP_SPLIT_BANK: offchip = eff_addr >= EMCFG_ONCHIP_LIMIT;
      default: offchip = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_write_q <= 1'b0;
      op_wide_q <= 1'b0;
      op_offchip_q <= 1'b0;
      op_mux_q <= 1'b0;
      op_addr_q <= 16'h0;
      op_wdata_q <= 8'h0;
      last_offchip_q <= 1'b0;
      xmove_eff_addr <= 16'h0;
      xmove_onchip <= 1'b0;
    end else if (state_q == EMCFG_ST_IDLE && xmove_start) begin
      op_write_q <= xmove_is_write;
      op_wide_q <= xmove_wide;
      // without route enable the pins stay disconnected
      op_offchip_q <= offchip & pin_route_enable;
      op_mux_q <= ~mux_select;
      op_addr_q <= eff_addr;
      op_wdata_q <= xmove_wdata;
      last_offchip_q <= offchip;
      // on-chip space aliases on 4 kB, upper bits cleared
      xmove_eff_addr <= offchip ? eff_addr : (eff_addr & (EMCFG_ONCHIP_LIMIT - 16'h1));
      xmove_onchip <= ~offchip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // move sequencer
  emcfg_tmr_if tmr_if ();
  logic tmr_load;
  logic [1:0] tmr_count;

  emcfg_phase_tmr u_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .tmr(tmr_if.timer)
  );

  assign tmr_if.load = tmr_load;
  assign tmr_if.count = tmr_count;

  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_count = latch_pulse_width;
    case (state_q)
      EMCFG_ST_IDLE: begin
        if (xmove_start) begin
          if (offchip && pin_route_enable && !mux_select) begin
            state_d = EMCFG_ST_ALE_HI;
            tmr_load = 1'b1;
          end else if (offchip && pin_route_enable) begin
            state_d = EMCFG_ST_STROBE;
            tmr_load = 1'b1;
            tmr_count = EMCFG_STROBE_CODE;
          end else begin
            state_d = EMCFG_ST_DONE;
          end
        end
      end
      EMCFG_ST_ALE_HI: begin
        if (tmr_if.expired) begin
          state_d = EMCFG_ST_ALE_LO;
          tmr_load = 1'b1;
        end
      end
      EMCFG_ST_ALE_LO: begin
        if (tmr_if.expired) begin
          state_d = EMCFG_ST_STROBE;
          tmr_load = 1'b1;
          tmr_count = EMCFG_STROBE_CODE;
        end
      end
      EMCFG_ST_STROBE: begin
        if (tmr_if.expired) begin
          state_d = EMCFG_ST_DONE;
        end
      end
      EMCFG_ST_DONE: state_d = EMCFG_ST_IDLE;
      default: state_d = EMCFG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= EMCFG_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xmove_done <= 1'b0;
    end else begin
      xmove_done <= (state_q == EMCFG_ST_DONE);
    end
  end

  // on-chip data comes from the xram itself; this path returns zero then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xmove_rdata <= 8'h0;
    end else if (state_q == EMCFG_ST_IDLE && xmove_start) begin
      xmove_rdata <= 8'h0;
    end else if (state_q == EMCFG_ST_STROBE && tmr_if.expired && !op_write_q) begin
      // data sits on port 7 in both pin layouts
      xmove_rdata <= port_pin_in[31:24];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin steering
  logic claim;
  logic drive_hi;
  logic strobe;
  logic [31:0] pin_d, oe_d;

  // pins belong to the interface only inside an off-chip move
  assign claim = op_offchip_q && (state_q == EMCFG_ST_ALE_HI || state_q == EMCFG_ST_ALE_LO
                 || state_q == EMCFG_ST_STROBE);
  // no-bank split mode leaves A15:8 to the port latch on 8-bit moves
  assign drive_hi = op_wide_q || map_mode != EMCFG_MAP_SPLIT_NOBANK;
  assign strobe = state_q == EMCFG_ST_STROBE;

  always_comb begin
    // outside a move the latches own the pins; push-pull or open-drain is
    // applied downstream by the output mode registers, never here
    pin_d = port_latch;
    oe_d = 32'hffff_ffff;
    if (claim) begin
      pin_d[EMCFG_RD_N_BIT] = ~(strobe & ~op_write_q);
      pin_d[EMCFG_WR_N_BIT] = ~(strobe & op_write_q);
      pin_d[EMCFG_ALE_BIT] = (state_q == EMCFG_ST_ALE_HI);
      if (drive_hi) begin
        pin_d[23:16] = op_addr_q[15:8];
      end
      if (op_mux_q) begin
        // port 5 untouched in multiplexed operation
        pin_d[31:24] = strobe ? op_wdata_q : op_addr_q[7:0];
        oe_d[31:24] = {8{~strobe | op_write_q}};
      end else begin
        pin_d[15:8] = op_addr_q[7:0];
        pin_d[31:24] = op_wdata_q;
        oe_d[31:24] = {8{op_write_q}};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_pin_out <= 32'hffff_ffff;
      port_pin_oe <= 32'h0;
    end else begin
      port_pin_out <= pin_d;
      port_pin_oe <= oe_d;
    end
  end
endmodule : emcfg_top

// File: shared/emcfg_pkg.sv
// Summary of operation
// - routed interface uses P7..P4, or P7,P6,P4 multiplexed
// - route enable bit connects interface to P4-P7
// - pins claimed only during off-chip external move
// - pins return to port latches when move completes
// - drivers off on pins acting as inputs
// - output mode stays with port output mode registers
// - mode field selects on-chip, split or off-chip map
// - config bit four selects multiplexed or separate pins
// - low address on shared pins while latch strobe high
// - latch strobe high and low widths 1 to 4 clocks
// - bank select mode drives all sixteen address lines
package emcfg_pkg;
  localparam logic [3:0] EMCFG_PAGE_OFS = 4'h0;
  localparam logic [3:0] EMCFG_CFG_OFS = 4'h4;
  localparam logic [3:0] EMCFG_STAT_OFS = 4'h8;
  localparam logic [7:0] EMCFG_PAGE_RST = 8'h00;
  localparam logic [7:0] EMCFG_CFG_RST = 8'h03;
  localparam logic [7:0] EMCFG_CFG_WMASK = 8'h3f;
  localparam int EMCFG_ROUTE_BIT = 5;
  localparam int EMCFG_MUX_BIT = 4;
  localparam int EMCFG_MODE_LSB = 2;
  localparam int EMCFG_ALE_LSB = 0;
  localparam logic [15:0] EMCFG_ONCHIP_LIMIT = 16'h1000;
  // strobe phase length code, same coding as the latch width (code+1 clocks)
  localparam logic [1:0] EMCFG_STROBE_CODE = 2'h1;
  // control lanes inside port 4
  localparam int EMCFG_RD_N_BIT = 7;
  localparam int EMCFG_WR_N_BIT = 6;
  localparam int EMCFG_ALE_BIT = 5;

  typedef enum logic [1:0] {
    EMCFG_MAP_ONCHIP = 2'h0,
    EMCFG_MAP_SPLIT_NOBANK = 2'h1,
    EMCFG_MAP_SPLIT_BANK = 2'h2,
    EMCFG_MAP_OFFCHIP = 2'h3
  } emcfg_map_t;

  typedef enum logic [4:0] {
    EMCFG_ST_IDLE = 5'h01,
    EMCFG_ST_ALE_HI = 5'h02,
    EMCFG_ST_ALE_LO = 5'h04,
    EMCFG_ST_STROBE = 5'h08,
    EMCFG_ST_DONE = 5'h10
  } emcfg_state_t;
endpackage : emcfg_pkg

// File: shared/emcfg_tmr_if.sv
interface emcfg_tmr_if;
  logic load;
  logic [1:0] count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface : emcfg_tmr_if

// File: hw/emcfg_phase_tmr.sv
module emcfg_phase_tmr (
  input wire logic clk,
  input wire logic rst_n,
  emcfg_tmr_if.timer tmr
);
  logic [1:0] cnt_q;

  // a phase loaded with code k lasts k+1 clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else if (tmr.load) begin
      cnt_q <= tmr.count;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  assign tmr.expired = (cnt_q == 2'h0);
endmodule : emcfg_phase_tmr

// File: test/emcfg_top_chk.sv
module emcfg_top_chk
  import emcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic xmove_start,
  input wire logic xmove_wide,
  input wire logic [15:0] xmove_wide_addr,
  input wire logic [7:0] xmove_low_addr,
  input wire logic xmove_done,
  input wire logic xmove_onchip,
  input wire logic [15:0] xmove_eff_addr,
  input wire logic [31:0] port_latch,
  input wire logic [31:0] port_pin_out,
  input wire logic [31:0] port_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act_q, up_q;
  logic [7:0] cfg_q, pg_q;
  logic [15:0] ea_q;
  logic [2:0] ale_q;
  wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic strb = act_q && !(port_pin_out[EMCFG_RD_N_BIT] && port_pin_out[EMCFG_WR_N_BIT]);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////
  // mirror follows the low byte lane, as the register file does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 1'b0;
      up_q <= 1'b0;
      cfg_q <= EMCFG_CFG_RST;
      pg_q <= EMCFG_PAGE_RST;
    end else begin
      act_q <= xmove_start || (act_q && !xmove_done);
      up_q <= 1'b1;
      if (wr_ok && avs_address == EMCFG_CFG_OFS)
        cfg_q <= avs_writedata[7:0] & EMCFG_CFG_WMASK;
      if (wr_ok && avs_address == EMCFG_PAGE_OFS)
        pg_q <= avs_writedata[7:0];
    end
  end
  always_ff @(posedge clk)
    if (xmove_start)
      ea_q <= xmove_wide ? xmove_wide_addr : {pg_q, xmove_low_addr};
  always_ff @(posedge clk)
    ale_q <= port_pin_out[EMCFG_ALE_BIT] ? ale_q + 3'h1 : 3'h0;
  ////////
  property p_cfg_top;
    avs_read && !avs_waitrequest && avs_address == EMCFG_CFG_OFS |-> avs_readdata[31:6] == 26'h0;
  endproperty
  a_cfg_top: assert property (p_cfg_top) else $error("config top bits set");
  property p_idle;
    up_q && !act_q && !$past(act_q) |-> port_pin_out == $past(port_latch) && &port_pin_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("pins not with latches");
  property p_hiz;
    act_q && port_pin_oe[EMCFG_RD_N_BIT] && !port_pin_out[EMCFG_RD_N_BIT] |-> !(|port_pin_oe[31:24]);
  endproperty
  a_hiz: assert property (p_hiz) else $error("data driven in read");
  property p_mux_p5;
    act_q && !cfg_q[EMCFG_MUX_BIT] |-> port_pin_out[15:8] == $past(port_latch[15:8]);
  endproperty
  a_mux_p5: assert property (p_mux_p5) else $error("port 5 taken");
  property p_ale_addr;
    act_q && port_pin_out[EMCFG_ALE_BIT] && !cfg_q[EMCFG_MUX_BIT] |-> port_pin_out[31:24] == ea_q[7:0];
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("low address absent");
  property p_ale_w;
    act_q && $fell(port_pin_out[EMCFG_ALE_BIT]) |-> ale_q == cfg_q[1:0] + 3'h1;
  endproperty
  a_ale_w: assert property (p_ale_w) else $error("strobe width");
  property p_onchip;
    xmove_start && cfg_q[3:2] == 2'h0 |-> ##2 xmove_done ##1 xmove_onchip && xmove_eff_addr == {4'h0, ea_q[11:0]};
  endproperty
  a_onchip: assert property (p_onchip) else $error("on-chip move");
  property p_bank;
    strb && cfg_q[3:2] == 2'h2 |-> port_pin_out[23:16] == ea_q[15:8];
  endproperty
  a_bank: assert property (p_bank) else $error("high address");
endmodule : emcfg_top_chk
bind emcfg_top emcfg_top_chk chk (.*);

// File: test/emcfg_mem_model.sv
module emcfg_mem_model
  import emcfg_pkg::*;
(
  input wire logic clk,
  input wire logic mux,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] adr_q;
  logic [7:0] adr;
  always_ff @(posedge clk) begin
    if (mux && pin_out[EMCFG_ALE_BIT])
      adr_q <= pin_out[31:24];
    if (pin_oe[EMCFG_WR_N_BIT] && !pin_out[EMCFG_WR_N_BIT])
      mem[adr] <= pin_out[31:24];
  end
  ////////
  // released lines show the inverse of the last drive, never a stale match
  always_comb begin
    adr = mux ? adr_q : pin_out[15:8];
    pin_in = (pin_out & pin_oe) | ~(pin_out | pin_oe);
    if (pin_oe[EMCFG_RD_N_BIT] && !pin_out[EMCFG_RD_N_BIT])
      pin_in[31:24] = mem[adr];
  end
endmodule : emcfg_mem_model

// File: test/emcfg_top_test.sv
module emcfg_top_test import emcfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic xmove_start, xmove_is_write, xmove_wide, xmove_done, xmove_onchip;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, port_latch, port_pin_in, port_pin_out, port_pin_oe;
  logic [15:0] xmove_wide_addr, xmove_eff_addr;
  logic [7:0] xmove_low_addr, xmove_wdata, xmove_rdata, cfg;
  logic [7:0] fix [5] = '{8'h03, 8'hff, 8'h28, 8'h34, 8'h2f};
  int fails, total_checks, seed;
  emcfg_top dut (.*);
  emcfg_mem_model mdl (.clk(clk), .mux(!cfg[EMCFG_MUX_BIT]), .pin_out(port_pin_out),
    .pin_oe(port_pin_oe), .pin_in(port_pin_in));
  ////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic mv(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    xmove_start <= 1'b1;
    xmove_is_write <= w;
    xmove_wide_addr <= a;
    xmove_low_addr <= a[7:0];
    xmove_wdata <= d;
    @(posedge clk);
    xmove_start <= 1'b0;
    while (xmove_done !== 1'b1) @(posedge clk);
    q = xmove_rdata;
  endtask : mv
  // on-chip flag and effective address for a map mode and full address
  function automatic logic [16:0] expect_ea(input logic [1:0] m, input logic [15:0] f);
    logic on;
    on = m == 2'h0 || (m != 2'h3 && f < EMCFG_ONCHIP_LIMIT);
    return on ? {1'b1, 4'h0, f[11:0]} : {1'b0, f};
  endfunction : expect_ea
  task automatic step(input logic [7:0] c, input logic [7:0] p, input logic [15:0] a,
    input logic w, input logic [7:0] d);
    logic [16:0] e;
    logic [31:0] r;
    logic [7:0] x;
    cfg <= c;
    port_latch <= {8'hff, 8'($random(seed)), 8'($random(seed)), 3'h6, 5'($random(seed))};
    bus(1'b1, EMCFG_CFG_OFS, c, r);
    bus(1'b0, EMCFG_CFG_OFS, 8'h0, r);
    chk("config", {24'h0, c & 8'h3f}, r);
    bus(1'b1, EMCFG_PAGE_OFS, p, r);
    xmove_wide <= w;
    e = expect_ea(c[3:2], w ? a : {p, a[7:0]});
    mv(1'b1, a, d, x);
    @(posedge clk);
    chk("onchip_addr", {15'h0, e}, {15'h0, xmove_onchip, xmove_eff_addr});
    mv(1'b0, a, 8'h0, x);
    chk("rdata", (e[16] || !c[5]) ? 32'h0 : {24'h0, d}, {24'h0, x});
    bus(1'b0, EMCFG_STAT_OFS, 8'h0, r);
    chk("status", {30'h0, !e[16], 1'b0}, r);
  endtask : step
  ////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a full run needs under 2500 cycles
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic [7:0] c, p;
    logic [15:0] a;
    seed = 32'he6db8c79;
    {rst_n, avs_read, avs_write, xmove_start, xmove_is_write, xmove_wide} = 6'h0;
    {avs_address, avs_writedata, xmove_wide_addr, xmove_low_addr, xmove_wdata} = 68'h0;
    avs_byteenable = 4'hf;
    port_latch = 32'hffffffdf; // parked high, latch strobe parked low
    cfg = 8'h03;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, EMCFG_PAGE_OFS, 8'h0, r);
    chk("page_reset", 32'h0, r);
    bus(1'b0, EMCFG_CFG_OFS, 8'h0, r);
    chk("config_reset", 32'h3, r);
    bus(1'b0, 4'hc, 8'h0, r);
    chk("unmapped", 32'h0, r);
    avs_byteenable <= 4'he;
    bus(1'b1, EMCFG_CFG_OFS, 8'h3c, r);
    avs_byteenable <= 4'hf;
    bus(1'b0, EMCFG_CFG_OFS, 8'h0, r);
    chk("config_lane", 32'h3, r);
    for (int i = 0; i < 60; i++) begin
      c = 8'($random(seed));
      p = 8'($random(seed));
      a = 16'($random(seed));
      step(i < 5 ? fix[i] : c, i[0] ? p & 8'h0f : p, i[0] ? a & 16'h0fff : a, c[7],
        8'($random(seed)));
    end
    finish_test();
  end
endmodule : emcfg_top_test
